// >>> core/srbc_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "srbc_map.vh"

// two-flop synchroniser for slow board level pins
// resets to the idle level so that leaving reset never looks like an edge
// only the second stage is read by anyone else
module srbc_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] IDLE_LEVEL = {WIDTH{1'b1}}
) (
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// raw pin levels
	input wire [WIDTH-1:0] async_in,
	// pin levels in the clock domain
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;

	// first stage may go metastable, the second gives it a cycle to settle
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_q <= IDLE_LEVEL;
			sync_out <= IDLE_LEVEL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// suspend/resume pin, battery-low pins and the dead-battery latch
// a pin edge reaches the mode register three edges after it lands:
// two synchroniser stages, then the edge compare, then the register
// pins are assumed to be debounced on the board; a bouncing switch
// gives one mode change per clean edge of the configured polarity that survives synchronisation
// the battery lines are independent; only the dead line has a latch
module srbc_ctrl (
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// board power pins
	input wire suspend_resume_in,
	input wire [2:0] battery_low_in,
	input wire all_clear_in,
	output reg latched_battery_dead_out,
	// indexed configuration space port
	input wire [7:0] cfg_index_in,
	input wire [7:0] cfg_wdata_in,
	input wire cfg_wr_in,
	input wire cfg_rd_in,
	output reg [7:0] cfg_rdata_out,
	// mode requests and state
	input wire [2:0] mode_req_in,
	input wire mode_req_valid_in,
	output reg [2:0] power_mode_out,
	output reg [2:0] battery_event_out
);
	// power modes as state codes
	localparam [2:0] ST_HYPER = `SRBC_MODE_HYPER;
	localparam [2:0] ST_HIGH = `SRBC_MODE_HIGH;
	localparam [2:0] ST_LOW = `SRBC_MODE_LOW;
	localparam [2:0] ST_STANDBY = `SRBC_MODE_STANDBY;
	localparam [2:0] ST_SUSPEND = `SRBC_MODE_SUSPEND;

	// synchronised pins and their values one cycle earlier
	wire sus_sync;
	wire [2:0] bl_sync;
	reg sus_prev_q;
	reg [2:0] bl_prev_q;
	// edge register and next mode
	reg [7:0] pin_cfg_q;
	reg [2:0] mode_d;
	// decoded events
	wire sus_rise;
	wire sus_fall;
	wire sus_edge;
	wire res_edge;
	wire [2:0] bl_fall;
	wire force_dead;
	wire cfg_hit;

	// the suspend/resume pin sits idle high
	srbc_sync #(
		.WIDTH(1),
		.IDLE_LEVEL(1'b1)
	) sus_sync_u (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.async_in(suspend_resume_in),
		.sync_out(sus_sync)
	);

	// battery lines share one synchroniser so their stages stay aligned
	srbc_sync #(
		.WIDTH(3),
		.IDLE_LEVEL(3'h7)
	) bl_sync_u (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.async_in(battery_low_in),
		.sync_out(bl_sync)
	);

	// edge history; reset high matches the idle pins, so no false edge
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sus_prev_q <= 1'b1;
			bl_prev_q <= 3'h7;
		end else begin
			sus_prev_q <= sus_sync;
			bl_prev_q <= bl_sync;
		end
	end

	// one-cycle edge pulses from the settled copies
	assign sus_rise = sus_sync & ~sus_prev_q;
	assign sus_fall = ~sus_sync & sus_prev_q;
	// suspend and resume have separate polarity bits on the same pin
	assign sus_edge = pin_cfg_q[`SRBC_SUS_RISE_BIT] ? sus_rise : sus_fall;
	assign res_edge = pin_cfg_q[`SRBC_RES_RISE_BIT] ? sus_rise : sus_fall;
	// battery lines only act on the low-going edge
	assign bl_fall = bl_prev_q & ~bl_sync;
	// the dead-battery edge forces suspend only when software allows it
	assign force_dead = pin_cfg_q[`SRBC_BL_FORCE_BIT] & bl_fall[2];
	// only one index of the shared configuration space lives here
	assign cfg_hit = (cfg_index_in == `SRBC_IDX_PIN_CFG);

	// edge register write; writes to other indices are ignored here
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_cfg_q <= `SRBC_PIN_CFG_RESET;
		end else if (cfg_wr_in && cfg_hit) begin
			pin_cfg_q <= cfg_wdata_in;
		end
	end

	// registered read-back; a write in the same cycle shows at the next read
	// the value stands until the next read so a slow master can fetch it
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_rdata_out <= 8'h00;
		end else if (cfg_rd_in) begin
			if (cfg_hit) begin
				cfg_rdata_out <= pin_cfg_q;
			end else begin
				cfg_rdata_out <= 8'h00; // unclaimed indices read as zero
			end
		end
	end

	// next mode: battery force beats the pin, the pin beats software
	// software requests are ignored in suspend; only the pin wakes the chip
	always @* begin
		mode_d = power_mode_out;
		case (power_mode_out)
			ST_HYPER, ST_HIGH, ST_LOW, ST_STANDBY: begin
				if (force_dead) begin
					mode_d = ST_SUSPEND;
				end else if (sus_edge) begin
					mode_d = ST_SUSPEND;
				end else if (mode_req_valid_in && mode_req_in <= ST_SUSPEND) begin
					mode_d = mode_req_in;
				end
			end
			ST_SUSPEND: begin
				// no resume while the dead-battery latch is still low
				if (res_edge && latched_battery_dead_out) begin
					if (pin_cfg_q[`SRBC_RES_LOW_BIT]) begin
						mode_d = ST_LOW;
					end else begin
						mode_d = ST_HIGH;
					end
				end
			end
			default: begin
				mode_d = ST_HIGH; // unused codes fall back to a run mode
			end
		endcase
	end

	// mode register
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			power_mode_out <= ST_HIGH;
		end else begin
			power_mode_out <= mode_d;
		end
	end

	// one pulse per falling battery line, for software to count
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			battery_event_out <= 3'h0;
		end else begin
			battery_event_out <= bl_fall;
		end
	end

	// dead-battery latch; a new dead edge wins over a same-cycle all clear
	// all_clear_in is taken as a settled level from the board logic,
	// so a glitch on it could release the latch early
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			latched_battery_dead_out <= 1'b1;
		end else if (bl_fall[2]) begin
			latched_battery_dead_out <= 1'b0;
		end else if (all_clear_in) begin
			latched_battery_dead_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> core/srbc_map.vh
`ifndef SRBC_MAP_VH
`define SRBC_MAP_VH
// configuration index of the pin edge register
`define SRBC_IDX_PIN_CFG 8'h50
`define SRBC_PIN_CFG_RESET 8'h00
// field positions inside the pin edge register
`define SRBC_SUS_RISE_BIT 0
`define SRBC_RES_RISE_BIT 1
`define SRBC_RES_LOW_BIT 2
`define SRBC_BL_FORCE_BIT 3
// power modes
`define SRBC_MODE_HYPER 3'h0
`define SRBC_MODE_HIGH 3'h1
`define SRBC_MODE_LOW 3'h2
`define SRBC_MODE_STANDBY 3'h3
`define SRBC_MODE_SUSPEND 3'h4
`endif

// >>> verification/srbc_board.sv
`timescale 1ns/100ps
`default_nettype none
module srbc_board(input wire logic sw_in, input wire logic [2:0] bat_in, input wire logic ok_in,
	output wire logic sr_out, output wire logic [2:0] bl_out, output wire logic ac_out);
	// switch and monitor lines; all clear only once the dead line recovers
	assign sr_out = sw_in;
	assign bl_out = bat_in;
	assign ac_out = ok_in & bat_in[2];
endmodule
`default_nettype wire

// >>> verification/srbc_mon_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module srbc_mon(input wire logic clk_in, rstn_in, suspend_resume_in, all_clear_in, cfg_rd_in, cfg_wr_in,
	latched_battery_dead_out, input wire logic [2:0] battery_low_in, power_mode_out, battery_event_out,
	input wire logic [7:0] cfg_index_in, cfg_wdata_in, cfg_rdata_out);
	logic [7:0] cfg_q;
	// mirror of the edge register, rebuilt from port writes
	always @(posedge clk_in or negedge rstn_in)
		if (!rstn_in) cfg_q <= 8'h00;
		else if (cfg_wr_in && cfg_index_in == 8'h50) cfg_q <= cfg_wdata_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_susp; ##[2:4] power_mode_out == 3'h4; endsequence
	AST_SUS: assert property (power_mode_out != 3'h4 &&
		(cfg_q[0] ? $rose(suspend_resume_in) : $fell(suspend_resume_in)) |-> s_susp) else $error("no suspend");
	AST_RES: assert property (power_mode_out == 3'h4 && latched_battery_dead_out &&
		(cfg_q[1] ? $rose(suspend_resume_in) : $fell(suspend_resume_in)) |-> ##[2:4]
		power_mode_out == (cfg_q[2] ? 3'h2 : 3'h1)) else $error("no resume");
	AST_CFG: assert property (cfg_rd_in |=> cfg_rdata_out ==
		($past(cfg_index_in) == 8'h50 ? $past(cfg_q) : 8'h00)) else $error("bad readback");
	AST_EVT: assert property ($fell(battery_low_in[0]) |-> ##[2:4] battery_event_out[0]) else $error("no event");
	AST_DEAD: assert property ($fell(battery_low_in[2]) |-> ##[2:4] !latched_battery_dead_out) else $error("no latch");
	AST_HOLD: assert property (!latched_battery_dead_out && !all_clear_in |=> !latched_battery_dead_out) else $error("drop");
	AST_ONE: assert property ((battery_event_out & $past(battery_event_out)) == 3'h0) else $error("long pulse");
endmodule
bind srbc_ctrl srbc_mon M(.*);
`default_nettype wire

// >>> verification/suspend_resume_battery_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module suspend_resume_battery_control_tb;
	logic clk_in = 0, rstn_in = 0, sw = 1, ok = 1, wr = 0, rd = 0, rv = 0, sr, ac, lat;
	logic [2:0] bat = 3'h7, req = 3'h0, bl, mode, ev;
	logic [7:0] idx = 8'h00, wd = 8'h00, rdat;
	int err_total = 0, samples_checked = 0, n;
	always #2.5 clk_in = ~clk_in;
	srbc_board B(.sw_in(sw), .bat_in(bat), .ok_in(ok), .sr_out(sr), .bl_out(bl), .ac_out(ac));
	srbc_ctrl DUT(.clk_in(clk_in), .rstn_in(rstn_in), .suspend_resume_in(sr), .battery_low_in(bl), .all_clear_in(ac),
		.latched_battery_dead_out(lat), .cfg_index_in(idx), .cfg_wdata_in(wd), .cfg_wr_in(wr), .cfg_rd_in(rd),
		.cfg_rdata_out(rdat), .mode_req_in(req), .mode_req_valid_in(rv), .power_mode_out(mode), .battery_event_out(ev));
	task chk(input string s, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin err_total++; $display("wrong value %s exp %h got %h", s, e, g); end
	endtask
	// write then read back at once, back to back
	task cw(input logic [7:0] i, d);
		idx = i; wd = d; wr = 1; @(negedge clk_in); wr = 0; rd = 1; @(negedge clk_in); rd = 0; @(negedge clk_in);
	endtask
	task pin(input logic v, input logic [2:0] e);
		sw = v; repeat (6) @(negedge clk_in); chk("mode", {5'h00, e}, {5'h00, mode});
	endtask
	// one-cycle software mode request, then the mode it should leave
	task rq(input logic [2:0] m, e);
		req = m; rv = 1; @(negedge clk_in); rv = 0; @(negedge clk_in); chk("req", {5'h00, e}, {5'h00, mode});
	endtask
	// rising suspend edge from standby and hyper; requests refused in suspend
	task t_req;
		cw(8'h50, 8'h01); rq(3'h3, 3'h3); pin(0, 3'h3); pin(1, 3'h4);
		rq(3'h0, 3'h4); pin(0, 3'h1); rq(3'h0, 3'h0); pin(1, 3'h4); pin(0, 3'h1);
	endtask
	task t_cfg;
		cw(8'h51, 8'h3c); chk("unmapped", 8'h00, rdat);
		cw(8'h50, 8'h06); chk("cfg", 8'h06, rdat);
	endtask
	task t_pin;
		pin(0, 3'h4); pin(1, 3'h2); cw(8'h50, 8'h00); pin(1, 3'h2);
		pin(0, 3'h4); pin(1, 3'h4); pin(0, 3'h1); pin(1, 3'h1);
	endtask
	task t_bat;
		cw(8'h50, 8'h08); ok = 0; bat = 3'h6; n = 0;
		repeat (6) begin @(negedge clk_in); n += ev[0]; end
		chk("events", 8'h01, n[7:0]);
		bat = 3'h2; ok = 1; n = 0;
		repeat (6) begin @(negedge clk_in); n += ev[2]; end
		chk("dead events", 8'h01, n[7:0]);
		chk("dead", 8'h00, {7'h00, lat});
		chk("forced", 8'h04, {5'h00, mode});
		bat = 3'h7; repeat (6) @(negedge clk_in); chk("clear", 8'h01, {7'h00, lat});
	endtask
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin repeat (2) @(negedge clk_in); rstn_in = 1; t_cfg; t_pin; t_req; t_bat; finish_test; end
	initial begin #5000; err_total++; finish_test; end
endmodule
`default_nettype wire
